//--- hdl/i2cm_pkg.sv
// shared constants and types for the two-wire master controller
// assumes a 32-bit AHB-Lite register bus and byte addressed registers
package i2cm_pkg;
    // register byte addresses
    localparam logic [7:0] OFF_RCV = 8'h00;
    localparam logic [7:0] OFF_TRN = 8'h04;
    localparam logic [7:0] OFF_BRG = 8'h08;
    localparam logic [7:0] OFF_CON = 8'h0C;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_ADD = 8'h14;
    localparam logic [7:0] OFF_EVT = 8'h18;
    // control fields
    localparam int CON_EN = 15;
    localparam int CON_ACCEPT_ALL = 11;
    localparam int CON_GENERAL_CALL_ENABLE = 7;
    localparam int CON_ACKDT = 5;
    localparam int CON_ACKEN = 4;
    localparam int CON_MASTER_RECEIVE_ENABLE = 3;
    localparam int CON_PEN = 2;
    localparam int CON_RSEN = 1;
    localparam int CON_SEN = 0;
    localparam logic [15:0] CON_RESET = 16'h1000;
    localparam logic [15:0] CON_REQ_MASK = 16'h001F;
    // status fields
    localparam int STAT_ACKSTAT = 15;
    localparam int STAT_MASTER_TRANSMIT_ACTIVE = 14;
    localparam int STAT_BCL = 10;
    localparam int STAT_GCSTAT = 9;
    localparam int STAT_STOP = 4;
    localparam int STAT_START = 3;
    localparam int STAT_RBF = 1;
    localparam int STAT_TBF = 0;
    // event register fields
    localparam int EVT_MASTER = 0;
    localparam int EVT_SLAVE = 1;
    localparam logic [7:0] GC_ADDR = 8'h00;
    localparam logic [3:0] LAST_TX = 4'h8;
    localparam logic [3:0] LAST_RX = 4'h7;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] ACK_BIT = 4'h9;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_START = 4'h1,
        ST_WAIT = 4'h2,
        ST_RS1 = 4'h3,
        ST_RS2 = 4'h4,
        ST_RS3 = 4'h5,
        ST_SP1 = 4'h6,
        ST_SP2 = 4'h7,
        ST_SP3 = 4'h8,
        ST_LOW = 4'h9,
        ST_HIGH = 4'hA
    } i2cm_state_e;

    typedef enum logic [1:0] {
        KIND_TX = 2'h0,
        KIND_RX = 2'h1,
        KIND_ACK = 2'h2
    } i2cm_kind_e;

    // line release request, high means let the line float
    typedef struct packed {
        logic scl_rel;
        logic sda_rel;
    } i2cm_lines_s;
endpackage

//--- hdl/i2cm_core.sv
// two-wire master engine with general call / accept-all address watch
// assumes external open-drain pads resolve o_*_oe_n, AHB-Lite single master
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module i2cm_core (
    input wire logic i_clk_sys, // 50 MHz system clock
    input wire logic i_rstn, // async reset, active low
    input wire logic i_hsel, // ahb slave select
    input wire logic [31:0] i_haddr, // ahb address
    input wire logic [1:0] i_htrans, // ahb transfer type
    input wire logic i_hwrite, // ahb write
    input wire logic [2:0] i_hsize, // ahb size
    input wire logic [31:0] i_hwdata, // ahb write data
    input wire logic i_hready, // ahb bus ready
    output logic [31:0] o_hrdata, // ahb read data
    output logic o_hreadyout, // ahb slave ready
    output logic o_hresp, // ahb response
    input wire logic i_scl, // clock line level
    output logic o_scl_out, // clock pad drive value
    output logic o_scl_oe_n, // clock pad enable, low drives
    input wire logic i_sda, // data line level
    output logic o_sda_out, // data pad drive value
    output logic o_sda_oe_n, // data pad enable, low drives
    input wire logic i_sleep, // device sleep request
    output logic o_master_event_flag, // sticky master event
    output logic o_slave_event_flag // sticky slave event
);
    function automatic logic sticky(input logic q, input logic set, input logic clr);
        sticky = set | (q & ~clr);
    endfunction

    logic [2:0] scl_q, sda_q;
    logic sleep1_q, sleep_q;
    logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            sleep1_q <= 1'b0;
            sleep_q <= 1'b0;
        end
        else
        begin
            scl_q <= {scl_q[1:0], i_scl};
            sda_q <= {sda_q[1:0], i_sda};
            sleep1_q <= i_sleep;
            sleep_q <= sleep1_q;
        end
    end
    assign scl_s = scl_q[1];
    assign sda_s = sda_q[1];
    assign scl_rise = scl_q[1] & ~scl_q[2];
    assign scl_fall = ~scl_q[1] & scl_q[2];
    assign start_det = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
    assign stop_det = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

    // bus slave, zero wait states
    logic aphase, wr_q, rd_rcv;
    logic [7:0] addr_q;
    logic [31:0] hrdata_q;
    logic [15:0] con_q, con_d;
    logic [7:0] brg_rel_q, trn_q, rcv_q, tx_sh_q, rsr_q, mon_sh_q;
    logic [9:0] add_q;
    logic wr_trn, wr_con, wr_brg, wr_add, wr_stat, wr_evt;
    logic tbf_q, rbf_q, bcl_q, gcstat_q, ackstat_q, pseen_q, sseen_q;
    logic evt_m_q, evt_s_q;
    i2cm_pkg::i2cm_state_e st_q, st_d;
    i2cm_pkg::i2cm_kind_e kind_q;
    // short local names for the package's state and kind codes
    localparam i2cm_pkg::i2cm_state_e ST_IDLE = i2cm_pkg::ST_IDLE;
    localparam i2cm_pkg::i2cm_state_e ST_START = i2cm_pkg::ST_START;
    localparam i2cm_pkg::i2cm_state_e ST_WAIT = i2cm_pkg::ST_WAIT;
    localparam i2cm_pkg::i2cm_state_e ST_RS1 = i2cm_pkg::ST_RS1;
    localparam i2cm_pkg::i2cm_state_e ST_RS2 = i2cm_pkg::ST_RS2;
    localparam i2cm_pkg::i2cm_state_e ST_RS3 = i2cm_pkg::ST_RS3;
    localparam i2cm_pkg::i2cm_state_e ST_SP1 = i2cm_pkg::ST_SP1;
    localparam i2cm_pkg::i2cm_state_e ST_SP2 = i2cm_pkg::ST_SP2;
    localparam i2cm_pkg::i2cm_state_e ST_SP3 = i2cm_pkg::ST_SP3;
    localparam i2cm_pkg::i2cm_state_e ST_LOW = i2cm_pkg::ST_LOW;
    localparam i2cm_pkg::i2cm_state_e ST_HIGH = i2cm_pkg::ST_HIGH;
    localparam i2cm_pkg::i2cm_kind_e KIND_TX = i2cm_pkg::KIND_TX;
    localparam i2cm_pkg::i2cm_kind_e KIND_RX = i2cm_pkg::KIND_RX;
    localparam i2cm_pkg::i2cm_kind_e KIND_ACK = i2cm_pkg::KIND_ACK;
    logic [3:0] cnt_q;
    logic [7:0] brg_q;
    logic brg_load, brg_zero, collide, abort, idle_ok, master_transmit_active;
    logic m_done, tx_go, rx_go, rx_done;
    logic [15:0] req_clr;
    i2cm_pkg::i2cm_lines_s want;
    logic out_bit;

    assign aphase = i_hsel & i_htrans[1] & i_hready;
    assign rd_rcv = aphase & ~i_hwrite & (i_haddr[7:0] == i2cm_pkg::OFF_RCV);
    assign wr_trn = wr_q & (addr_q == i2cm_pkg::OFF_TRN);
    assign wr_con = wr_q & (addr_q == i2cm_pkg::OFF_CON);
    assign wr_brg = wr_q & (addr_q == i2cm_pkg::OFF_BRG);
    assign wr_add = wr_q & (addr_q == i2cm_pkg::OFF_ADD);
    assign wr_stat = wr_q & (addr_q == i2cm_pkg::OFF_STAT);
    assign wr_evt = wr_q & (addr_q == i2cm_pkg::OFF_EVT);
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = hrdata_q;

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wr_q <= 1'b0;
            addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end
        else
        begin
            wr_q <= aphase & i_hwrite & (i_haddr[31:8] == 24'h00_0000);
            addr_q <= i_haddr[7:0];
            if (aphase & ~i_hwrite)
            begin
                hrdata_q <= 32'h0000_0000;
                if (i_haddr[31:8] == 24'h00_0000)
                begin
                    case (i_haddr[7:0])
                        i2cm_pkg::OFF_RCV: hrdata_q[7:0] <= rcv_q;
                        i2cm_pkg::OFF_TRN: hrdata_q[7:0] <= trn_q;
                        i2cm_pkg::OFF_BRG: hrdata_q[7:0] <= brg_rel_q;
                        i2cm_pkg::OFF_CON: hrdata_q[15:0] <= con_q;
                        i2cm_pkg::OFF_STAT: hrdata_q[15:0] <= {ackstat_q, master_transmit_active, 3'h0, bcl_q, gcstat_q,
                                                               4'h0, pseen_q, sseen_q, 1'b0, rbf_q, tbf_q};
                        i2cm_pkg::OFF_ADD: hrdata_q[9:0] <= add_q;
                        i2cm_pkg::OFF_EVT: hrdata_q[1:0] <= {evt_s_q, evt_m_q};
                        default: hrdata_q <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            brg_rel_q <= 8'h00;
            add_q <= 10'h000;
            trn_q <= 8'hFF;
        end
        else
        begin
            if (wr_brg)
                brg_rel_q <= i_hwdata[7:0];
            if (wr_add)
                add_q <= i_hwdata[9:0];
            if (wr_trn)
                trn_q <= i_hwdata[7:0];
        end
    end

    // control: software set of a request wins over the hardware clear
    always_comb
    begin
        con_d = con_q & ~req_clr;
        if (wr_con)
        begin
            con_d = i_hwdata[15:0];
            if (!idle_ok && !con_q[i2cm_pkg::CON_MASTER_RECEIVE_ENABLE])
                con_d[i2cm_pkg::CON_MASTER_RECEIVE_ENABLE] = 1'b0;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            con_q <= i2cm_pkg::CON_RESET;
        else
            con_q <= con_d;
    end

    // baud counter; halts at zero until next load
    assign brg_zero = (brg_q == 8'h00);
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            brg_q <= 8'h00;
        else if (brg_load)
            brg_q <= brg_rel_q;
        else if (!brg_zero)
            brg_q <= brg_q - 8'h01;
    end

    assign abort = sleep_q | ~con_q[i2cm_pkg::CON_EN];
    assign idle_ok = (st_q == ST_IDLE) | (st_q == ST_WAIT);
    assign master_transmit_active = (st_q == ST_LOW || st_q == ST_HIGH) && kind_q == KIND_TX;
    assign tx_go = idle_ok & tbf_q & ~con_q[i2cm_pkg::CON_SEN];
    assign rx_go = (st_q == ST_WAIT) & con_q[i2cm_pkg::CON_MASTER_RECEIVE_ENABLE];

    // bit value the master wants on the data line in bit states
    always_comb
    begin
        case (kind_q)
            KIND_TX: out_bit = (cnt_q == i2cm_pkg::LAST_TX) | tx_sh_q[7];
            KIND_ACK: out_bit = con_q[i2cm_pkg::CON_ACKDT];
            default: out_bit = 1'b1;
        endcase
    end

    // released data read low while clock high means another master won
    always_comb
    begin
        collide = 1'b0;
        if (scl_s && !sda_s)
        begin
            // receive bits and the slave's ack slot are listened to, not driven
            if (st_q == ST_HIGH && out_bit && !scl_rise && kind_q != KIND_RX &&
                !(kind_q == KIND_TX && cnt_q == i2cm_pkg::LAST_TX))
                collide = 1'b1;
            // stop checked only once the released level has crossed the synchroniser
            if (st_q == ST_RS2 || (st_q == ST_SP3 && brg_zero))
                collide = 1'b1;
        end
    end

    always_comb
    begin
        st_d = st_q;
        brg_load = 1'b0;
        m_done = 1'b0;
        rx_done = 1'b0;
        req_clr = 16'h0000;
        want.scl_rel = 1'b1;
        want.sda_rel = 1'b1;
        case (st_q)
            ST_IDLE:
            begin
                brg_load = 1'b1;
                if (con_q[i2cm_pkg::CON_SEN])
                    st_d = ST_START;
                else if (tx_go)
                    st_d = ST_LOW;
            end
            ST_START:
            begin
                want.sda_rel = 1'b0;
                if (brg_zero)
                begin
                    st_d = ST_WAIT;
                    m_done = 1'b1;
                    req_clr[i2cm_pkg::CON_SEN] = 1'b1;
                    brg_load = 1'b1;
                end
            end
            ST_WAIT:
            begin
                // clock held low, data kept as it was
                want.scl_rel = 1'b0;
                want.sda_rel = o_sda_oe_n;
                brg_load = 1'b1;
                if (con_q[i2cm_pkg::CON_RSEN])
                    st_d = ST_RS1;
                else if (con_q[i2cm_pkg::CON_PEN])
                    st_d = ST_SP1;
                else if (tx_go)
                    st_d = ST_LOW;
                else if (rx_go || con_q[i2cm_pkg::CON_ACKEN])
                    st_d = ST_LOW;
            end
            ST_RS1, ST_SP1:
            begin
                want.scl_rel = 1'b0;
                want.sda_rel = (st_q == ST_RS1);
                if (brg_zero)
                begin
                    st_d = (st_q == ST_RS1) ? ST_RS2 : ST_SP2;
                    brg_load = 1'b1;
                end
            end
            ST_RS2, ST_SP2, ST_HIGH:
            begin
                // stop releases data on the same edge that leaves this phase
                want.sda_rel = (st_q == ST_SP2) ? (brg_zero & scl_s) : ((st_q == ST_RS2) | out_bit);
                brg_load = ~scl_s;
                if (brg_zero && scl_s)
                begin
                    brg_load = 1'b1;
                    if (st_q == ST_RS2)
                        st_d = ST_RS3;
                    else if (st_q == ST_SP2)
                        st_d = ST_SP3;
                    else if (cnt_q == ((kind_q == KIND_TX) ? i2cm_pkg::LAST_TX :
                                       (kind_q == KIND_RX) ? i2cm_pkg::LAST_RX : 4'h0))
                    begin
                        st_d = ST_WAIT;
                        m_done = 1'b1;
                        rx_done = (kind_q == KIND_RX);
                        req_clr[i2cm_pkg::CON_MASTER_RECEIVE_ENABLE] = (kind_q == KIND_RX);
                        req_clr[i2cm_pkg::CON_ACKEN] = (kind_q == KIND_ACK);
                    end
                    else
                        st_d = ST_LOW;
                end
            end
            ST_RS3:
            begin
                // restart ends with clock pulled low: bus stays ours
                want.sda_rel = 1'b0;
                if (brg_zero)
                begin
                    st_d = ST_WAIT;
                    m_done = 1'b1;
                    req_clr[i2cm_pkg::CON_RSEN] = 1'b1;
                    brg_load = 1'b1;
                end
            end
            ST_SP3:
            begin
                if (brg_zero)
                begin
                    st_d = ST_IDLE;
                    m_done = 1'b1;
                    req_clr[i2cm_pkg::CON_PEN] = 1'b1;
                end
            end
            ST_LOW:
            begin
                want.scl_rel = 1'b0;
                want.sda_rel = out_bit;
                if (brg_zero)
                begin
                    st_d = ST_HIGH;
                    brg_load = 1'b1;
                end
            end
            default:
                st_d = ST_IDLE;
        endcase
        if (collide || abort)
        begin
            st_d = ST_IDLE;
            req_clr = i2cm_pkg::CON_REQ_MASK;
            want.scl_rel = 1'b1;
            want.sda_rel = 1'b1;
            brg_load = 1'b1;
        end
    end

    // clock pad follows next state; data pad trails by a cycle so it moves after the fall
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_q <= ST_IDLE;
            o_scl_oe_n <= 1'b1;
            o_sda_oe_n <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
            o_scl_oe_n <= (st_d == ST_IDLE) | ((st_d == st_q) ? want.scl_rel : (st_d != ST_LOW &&
                          st_d != ST_WAIT && st_d != ST_RS1 && st_d != ST_SP1));
            o_sda_oe_n <= want.sda_rel;
        end
    end
    assign o_scl_out = 1'b0;
    assign o_sda_out = 1'b0;

    // bit engine: kind, count and shift registers
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            kind_q <= KIND_TX;
            cnt_q <= 4'h0;
            tx_sh_q <= 8'h00;
            rsr_q <= 8'h00;
            ackstat_q <= 1'b0;
        end
        else if (idle_ok && st_d == ST_LOW)
        begin
            cnt_q <= 4'h0;
            // whole byte reloaded, so a retry after collision starts at bit 7
            tx_sh_q <= trn_q;
            kind_q <= tx_go ? KIND_TX : (rx_go ? KIND_RX : KIND_ACK);
        end
        else if (st_q == ST_HIGH)
        begin
            if (scl_rise && kind_q == KIND_RX)
                rsr_q <= {rsr_q[6:0], sda_s};
            if (scl_rise && kind_q == KIND_TX && cnt_q == i2cm_pkg::LAST_TX)
                ackstat_q <= sda_s;
            if (st_d == ST_LOW)
            begin
                cnt_q <= cnt_q + 4'h1;
                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            end
        end
    end

    // bus watcher: address byte after every start
    logic mon_on_q, gc_hit_q, own_hit_q, gc_now, own_now;
    logic [3:0] mon_cnt_q;
    logic [7:0] mon_byte;
    assign mon_byte = {mon_sh_q[6:0], sda_s};
    assign gc_now = scl_rise & mon_on_q & (mon_cnt_q == 4'h7) & con_q[i2cm_pkg::CON_GENERAL_CALL_ENABLE] &
                    (mon_byte == i2cm_pkg::GC_ADDR);
    assign own_now = con_q[i2cm_pkg::CON_ACCEPT_ALL] | (mon_byte[7:1] == add_q[6:0]);
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            mon_on_q <= 1'b0;
            mon_cnt_q <= 4'h0;
            mon_sh_q <= 8'h00;
            gc_hit_q <= 1'b0;
            own_hit_q <= 1'b0;
        end
        else if (start_det || sleep_q)
        begin
            mon_on_q <= ~sleep_q;
            mon_cnt_q <= 4'h0;
            gc_hit_q <= 1'b0;
            own_hit_q <= 1'b0;
        end
        else if (stop_det || (scl_fall && mon_cnt_q == i2cm_pkg::ACK_BIT))
            mon_on_q <= 1'b0;
        else if (mon_on_q && scl_rise && mon_cnt_q < i2cm_pkg::ACK_BIT)
        begin
            mon_cnt_q <= mon_cnt_q + 4'h1;
            if (mon_cnt_q < i2cm_pkg::BYTE_BITS)
                mon_sh_q <= mon_byte;
            if (mon_cnt_q == 4'h7)
            begin
                gc_hit_q <= gc_now;
                own_hit_q <= own_now;
            end
        end
    end

    logic ninth_fall;
    assign ninth_fall = mon_on_q & scl_fall & (mon_cnt_q == i2cm_pkg::ACK_BIT);

    // flags and receive buffer
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rcv_q <= 8'h00;
            rbf_q <= 1'b0;
            tbf_q <= 1'b0;
            bcl_q <= 1'b0;
            gcstat_q <= 1'b0;
            pseen_q <= 1'b0;
            sseen_q <= 1'b0;
            evt_m_q <= 1'b0;
            evt_s_q <= 1'b0;
        end
        else
        begin
            if (gc_now)
                rcv_q <= mon_byte;
            else if (rx_done)
                rcv_q <= rsr_q;
            rbf_q <= sticky(rbf_q, gc_now | rx_done, rd_rcv);
            tbf_q <= sticky(tbf_q & ~(collide | abort) & ~(m_done & kind_q == KIND_TX & st_q == ST_HIGH),
                            wr_trn, 1'b0);
            bcl_q <= sticky(bcl_q, collide, wr_stat & ~i_hwdata[i2cm_pkg::STAT_BCL]);
            gcstat_q <= sticky(gcstat_q, gc_now, start_det);
            pseen_q <= sticky(pseen_q, stop_det, start_det);
            sseen_q <= sticky(sseen_q, start_det, stop_det);
            evt_m_q <= sticky(evt_m_q, m_done | collide | stop_det | (ninth_fall & gc_hit_q),
                              wr_evt & i_hwdata[i2cm_pkg::EVT_MASTER]);
            evt_s_q <= sticky(evt_s_q, ninth_fall & own_hit_q,
                              wr_evt & i_hwdata[i2cm_pkg::EVT_SLAVE]);
        end
    end
    assign o_master_event_flag = evt_m_q;
    assign o_slave_event_flag = evt_s_q;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    brg_halt_a: assert property (brg_zero && !brg_load |=> brg_zero) else $error("baud counter left zero");
    brg_susp_a: assert property (st_q == ST_HIGH && !scl_s && !abort |=> brg_q == brg_rel_q)
        else $error("baud counter ran with clock low");
    tbf_set_a: assert property (wr_trn |=> tbf_q) else $error("buffer full not set by write");
    bcl_idle_a: assert property (collide |=> st_q == ST_IDLE && evt_m_q && bcl_q && !tbf_q && o_scl_oe_n)
        else $error("collision not handled");
    req_clr_a: assert property (collide && !wr_con |=> (con_q & i2cm_pkg::CON_REQ_MASK) == 16'h0000)
        else $error("requests survive collision");
    master_receive_enable_ign_a: assert property (wr_con && !idle_ok && !con_q[i2cm_pkg::CON_MASTER_RECEIVE_ENABLE] |=> !con_q[i2cm_pkg::CON_MASTER_RECEIVE_ENABLE])
        else $error("receive request taken while busy");
    sda_hold_a: assert property (st_q == ST_HIGH && $past(st_q) == ST_HIGH && !collide && !abort
        |=> $stable(o_sda_oe_n))
        else $error("data moved while clock high");
    stop_evt_a: assert property (stop_det && !wr_evt |=> evt_m_q) else $error("stop did not raise event");
    gc_rbf_a: assert property (gc_now |=> rbf_q && rcv_q == i2cm_pkg::GC_ADDR && gcstat_q)
        else $error("general call not buffered");
    sleep_a: assert property (sleep_q |=> st_q == ST_IDLE ##1 o_scl_oe_n && o_sda_oe_n)
        else $error("sleep did not abort");
    master_transmit_active_a: assert property (st_q == ST_LOW && kind_q == KIND_TX |-> master_transmit_active && tbf_q)
        else $error("transmit status wrong");
endmodule

//--- tb/i2cm_slave_model.sv
// two-wire slave model: acks address and written bytes, returns RD_BYTE on reads
// assumes the bench resolves both open-drain lines with pull-ups
`timescale 1ns/1ps
module i2cm_slave_model #(parameter logic [7:0] RD_BYTE = 8'hA5) (
    input wire logic i_scl, // clock line level
    input wire logic i_sda, // data line level
    input wire logic i_jam, // forces data low
    output logic o_sda_rel // high releases data
);
    logic [7:0] sh_q;
    logic [3:0] n_q = 4'h0;
    logic rel_q = 1'b1, rd_q = 1'b0, first_q = 1'b1;
    assign o_sda_rel = rel_q & ~i_jam;
    always @(negedge i_sda) if (i_scl) {n_q, first_q} = 5'h01;
    always @(posedge i_scl) {sh_q, n_q} = {sh_q[6:0], i_sda, n_q + 4'h1};
    // change data only while the clock is low
    always @(negedge i_scl)
    begin
        if (n_q == 4'h9) {n_q, first_q} = 5'h00;
        if (n_q == 4'h8 && first_q) rd_q = sh_q[0];
        if (n_q == 4'h8) rel_q = rd_q & ~first_q;
        else rel_q = ~(rd_q & ~first_q) | RD_BYTE[3'h7 - n_q[2:0]];
    end
endmodule

//--- tb/i2c_master_and_general_call_tb_top.sv
// bench for the two-wire master: register bus, transfers, collision, sleep
// assumes i2cm_core and i2cm_slave_model; both lines open drain with pull-ups
`timescale 1ns/1ps
module i2c_master_and_general_call_tb_top;
    typedef struct packed { logic [15:0] a, d, wb, ra, rm, re; } i2cm_row_s;
    logic i_clk_sys = 1'b0, i_rstn = 1'b0, i_hsel = 1'b1, i_hwrite = 1'b0, i_sleep = 1'b0, jam = 1'b0;
    logic [1:0] i_htrans = 2'h0;
    logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata;
    logic o_hreadyout, o_scl_out, o_scl_oe_n, o_sda_out, o_sda_oe_n, o_master_event_flag, sda_rel;
    logic o_slave_event_flag;
    logic [8:0] wire_q;
    int mismatches = 0, checks_done = 0;
    logic [31:0] rst_rows [6] = '{32'h000C_1000, 32'h0004_00FF, 32'h0008_0000, 32'h0010_0000, 32'h0018_0000,
        32'h0100_0000};
    // write address, data, wire bits (FFFF skips), read address, mask, expected
    i2cm_row_s seq [8] = '{96'h000C_8001_FFFF_000C_001F_0000, 96'h0004_00A0_0140_0010_C001_0000,
        96'h0004_003C_0078_000C_001F_0000, 96'h000C_8002_FFFF_000C_001F_0000, 96'h0004_00A1_0142_0010_C001_0000,
        96'h000C_8008_FFFF_0010_0002_0002, 96'h000C_8030_014B_0000_00FF_00A5, 96'h000C_8004_FFFF_0010_0010_0010};
    wire i_scl = o_scl_oe_n | o_scl_out;
    wire i_sda = (o_sda_oe_n | o_sda_out) & sda_rel;
    i2cm_core dut_u (.i_clk_sys, .i_rstn, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize(3'h2), .i_hwdata,
        .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp(), .i_scl, .o_scl_out, .o_scl_oe_n, .i_sda,
        .o_sda_out, .o_sda_oe_n, .i_sleep, .o_master_event_flag, .o_slave_event_flag);
    i2cm_slave_model slv_u (.i_scl, .i_sda, .i_jam(jam), .o_sda_rel(sda_rel));
    initial forever #10 i_clk_sys = ~i_clk_sys;
    always @(posedge i_scl) wire_q <= {wire_q[7:0], i_sda};
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) mismatches++;
        if (seen !== exp) $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one single transfer; read data compared under a mask
    task automatic xf(input logic wr, input logic [15:0] a, d, m, e);
        int k = 0;
        i_htrans <= 2'h2;
        i_haddr <= {16'h0, a};
        i_hwrite <= wr;
        do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1 && ++k < 9);
        i_htrans <= 2'h0;
        i_hwdata <= {16'h0, d};
        do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1 && ++k < 9);
        if (!wr) chk(o_hrdata & m, e);
        if (k == 9) mismatches++;
        if (k == 9) end_sim;
    endtask
    task automatic w(input logic [15:0] a, d);
        xf(1'b1, a, d, 16'h0, 16'h0);
    endtask
    task automatic wait_evt;
        int k = 0;
        while (o_master_event_flag !== 1'b1 && ++k < 3000) @(posedge i_clk_sys);
        if (k == 3000) mismatches++;
        if (k == 3000) end_sim;
        w(16'h18, 16'h1);
    endtask
    initial
    begin
        repeat (4) @(posedge i_clk_sys);
        chk({o_scl_oe_n, o_sda_oe_n}, 32'h3);
        i_rstn <= 1'b1;
        foreach (rst_rows[i]) xf(1'b0, rst_rows[i][31:16], 16'h0, 16'hFFFF, rst_rows[i][15:0]);
        w(16'h08, 16'h2);
        foreach (seq[i])
        begin
            w(seq[i].a, seq[i].d);
            wait_evt;
            if (seq[i].wb != 16'hFFFF) chk(wire_q, seq[i].wb);
            xf(1'b0, seq[i].ra, 16'h0, seq[i].rm, seq[i].re);
        end
        chk({o_scl_oe_n, o_sda_oe_n}, 32'h3);
        w(16'h0C, 16'h8001);
        wait_evt;
        w(16'h04, 16'hFF);
        // status is latched at the address phase: let the engine leave wait first
        repeat (2) @(posedge i_clk_sys);
        xf(1'b0, 16'h10, 16'h0, 16'h4001, 16'h4001);
        w(16'h0C, 16'h8008);
        xf(1'b0, 16'h0C, 16'h0, 16'h8, 16'h0);
        jam <= 1'b1;
        wait_evt;
        xf(1'b0, 16'h10, 16'h0, 16'h401, 16'h400);
        chk({o_scl_oe_n, o_sda_oe_n}, 32'h3);
        jam <= 1'b0;
        repeat (8) @(posedge i_clk_sys);
        chk(o_master_event_flag, 1'b1);
        w(16'h18, 16'h1);
        w(16'h0C, 16'h8001);
        wait_evt;
        w(16'h04, 16'h5A);
        wait_evt;
        chk(wire_q, 9'h0B4);
        // restart with general call and accept-all on, then send the all-zero address
        w(16'h14, 16'h7F);
        w(16'h0C, 16'h8882);
        wait_evt;
        w(16'h04, 16'h00);
        wait_evt;
        xf(1'b0, 16'h10, 16'h0, 16'h0202, 16'h0202);
        xf(1'b0, 16'h00, 16'h0, 16'h00FF, 16'h0000);
        chk(o_slave_event_flag, 1'b1);
        w(16'h04, 16'hC3);
        repeat (30) @(posedge i_clk_sys);
        i_sleep <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        chk({o_scl_oe_n, o_sda_oe_n}, 32'h3);
        end_sim;
    end
endmodule
